/* logic/sfsc_defs.svh */
`ifndef SFSC_DEFS_SVH
`define SFSC_DEFS_SVH

// opcodes
`define SFSC_OP_WR_ENABLE 8'h06
`define SFSC_OP_RDSR 8'h05
`define SFSC_OP_BOOST 8'ha3
`define SFSC_OP_RELEASE 8'hab
`define SFSC_OP_DEEP_PD 8'hb9
`define SFSC_OP_UID 8'h4b
`define SFSC_OP_SUSPEND 8'h75
`define SFSC_OP_RESUME 8'h7a
`define SFSC_OP_SEC_ERASE 8'h44
`define SFSC_OP_SEC_PROG 8'h42
`define SFSC_OP_SEC_READ 8'h48
`define SFSC_OP_RST_EN 8'h66
`define SFSC_OP_RESET 8'h99

// frame layout in bytes
`define SFSC_BIT_LAST 3'd7
`define SFSC_BYTE_SAT 3'd7
`define SFSC_LEN_OPCODE 3'd1
`define SFSC_ADDR_END 3'd3
`define SFSC_LEN_ADDR 3'd4
`define SFSC_DATA_START 3'd4

// security register address fields
`define SFSC_A_HI 23:16
`define SFSC_A_SEL 15:12
`define SFSC_A_GAP 11:10
`define SFSC_A_OFF 9:0
`define SFSC_A_PAGE 9:8
`define SFSC_SEC_BYTES 12'd1024
`define SFSC_PAGE_BYTES 12'd256
`define SFSC_MEM_LAST 3071
`define SFSC_ERASED 8'hff

// status byte bit positions
`define SFSC_SR_BUSY 0
`define SFSC_SR_LATCH 1
`define SFSC_SR_SUS_E 2
`define SFSC_SR_SUS_P 3
`define SFSC_SR_BOOST 4

// timing
`define SFSC_CLK_NS 4
`define SFSC_T_RST_US 30
`define SFSC_T_RST_E_MS 12
`define SFSC_HALF_CYC 4'd6

// controller registers
`define SFSC_REG_TX0 8'h00
`define SFSC_REG_TX1 8'h04
`define SFSC_REG_CMD 8'h08
`define SFSC_REG_STAT 8'h0c
`define SFSC_REG_RX0 8'h10
`define SFSC_REG_RX1 8'h14
`define SFSC_REG_RX2 8'h18
`define SFSC_REG_RX3 8'h1c
`define SFSC_CMD_NTX 3:0
`define SFSC_CMD_NRX 12:8
`endif

/* logic/sfsc_dev.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfsc_defs.svh"
module sfsc_dev #(
   // arbitrary value
   parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210,
   parameter int ERASE_CYC = 2048,
   parameter int PROG_CYC = 512,
   parameter int RST_CYC = `SFSC_T_RST_US * 1000 / `SFSC_CLK_NS,
   parameter int RST_E_CYC = `SFSC_T_RST_E_MS * 1000000 / `SFSC_CLK_NS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial link
   sfsc_if.dev link,
   // lock bits and flags
   input wire logic [2:0] otp_lock_bits,
   output logic op_in_progress_flag,
   output logic write_latch,
   output sfsc_pkg::sfsc_sel_t suspend_flags,
   output logic boost_flag
);
   import sfsc_pkg::*;

   function automatic sfsc_sel_t sec_sel(input logic [23:0] a);
      sec_sel = 2'd0;
      if (a[`SFSC_A_HI] == 8'h00 && a[`SFSC_A_GAP] == 2'b00 && a[15:14] == 2'b00) begin
         sec_sel = a[13:12];
      end
   endfunction

   logic [1:0] cs_sync_reg, sck_sync_reg, si_sync_reg;
   logic cs_d_reg, sck_d_reg;
   logic [2:0] bit_cnt_reg, byte_cnt_reg;
   logic [7:0] in_sh_reg, op_reg, out_sh_reg, pg_ptr_reg;
   logic [23:0] addr_reg;
   logic [9:0] rd_ptr_reg;
   logic [3:0] uid_idx_reg;
   logic so_reg, so_oe_n_reg;
   logic busy_reg, latch_reg, sus_e_reg, sus_p_reg, boost_reg, rst_en_reg;
   logic erase_act_reg, prog_act_reg;
   logic [11:0] erase_cnt_reg, prog_cnt_reg;
   logic [1:0] erase_sel_reg, prog_sel_reg, prog_page_reg;
   logic [21:0] recov_cnt_reg;
   logic [255:0] pvalid_reg;
   logic [7:0] mem [0:`SFSC_MEM_LAST];
   logic [7:0] pbuf [0:255];
   logic [7:0] status_byte;

   // two flops on every link input before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_sync_reg <= 2'b11;
         sck_sync_reg <= 2'b00;
         si_sync_reg <= 2'b00;
         cs_d_reg <= 1'b1;
         sck_d_reg <= 1'b0;
      end else begin
         cs_sync_reg <= {cs_sync_reg[0], link.cs_n};
         sck_sync_reg <= {sck_sync_reg[0], link.sclk};
         si_sync_reg <= {si_sync_reg[0], link.si};
         cs_d_reg <= cs_sync_reg[1];
         sck_d_reg <= sck_sync_reg[1];
      end
   end

   wire logic cs_n = cs_sync_reg[1];
   wire logic rise_ev = !cs_n && sck_sync_reg[1] && !sck_d_reg;
   wire logic fall_ev = !cs_n && !sck_sync_reg[1] && sck_d_reg;
   wire logic cs_rise = cs_n && !cs_d_reg;
   wire logic byte_done = rise_ev && (bit_cnt_reg == `SFSC_BIT_LAST);
   wire logic [7:0] byte_in = {in_sh_reg[6:0], si_sync_reg[1]};
   wire logic [7:0] op_now = (byte_cnt_reg == 3'd0) ? byte_in : op_reg;
   wire logic data_phase = byte_cnt_reg >= `SFSC_DATA_START;
   wire logic recov = recov_cnt_reg != 22'd0;
   wire sfsc_sel_t cmd_sel = sec_sel(addr_reg);
   wire logic [1:0] sel_idx = cmd_sel - 2'd1;
   wire logic sel_ok = cmd_sel != 2'd0;
   wire logic locked = otp_lock_bits[sel_idx];
   wire logic any_sus = sus_e_reg || sus_p_reg;

   // output byte selection
   wire logic [7:0] uid_byte = 8'(UNIQUE_ID >> {~uid_idx_reg, 3'b000});
   wire logic [7:0] sec_byte = sel_ok ? mem[{sel_idx, rd_ptr_reg}] : `SFSC_ERASED;
   wire logic is_rdsr = op_now == `SFSC_OP_RDSR;
   wire logic is_uid = op_now == `SFSC_OP_UID;
   wire logic is_read = op_now == `SFSC_OP_SEC_READ;
   wire logic out_load = byte_done && !recov && (is_rdsr || (data_phase && (is_uid || is_read)));
   wire logic [7:0] out_byte = is_rdsr ? status_byte : (is_uid ? uid_byte : sec_byte);
   wire logic buf_free = !prog_act_reg;
   wire logic buf_clr = byte_done && byte_cnt_reg == 3'd0 && byte_in == `SFSC_OP_SEC_PROG;
   wire logic buf_wr = byte_done && data_phase && op_reg == `SFSC_OP_SEC_PROG && buf_free;

   always_comb begin
      status_byte = 8'h00;
      status_byte[`SFSC_SR_BUSY] = busy_reg;
      status_byte[`SFSC_SR_LATCH] = latch_reg;
      status_byte[`SFSC_SR_SUS_E] = sus_e_reg;
      status_byte[`SFSC_SR_SUS_P] = sus_p_reg;
      status_byte[`SFSC_SR_BOOST] = boost_reg;
   end

   // frame decode at the rising chip select
   wire logic frame_ok = cs_rise && bit_cnt_reg == 3'd0 && !recov;
   wire logic len1 = byte_cnt_reg == `SFSC_LEN_OPCODE;
   wire logic len4 = byte_cnt_reg == `SFSC_LEN_ADDR;
   wire logic op_is_rls = op_reg == `SFSC_OP_RELEASE || op_reg == `SFSC_OP_DEEP_PD;
   wire logic do_write_enable = frame_ok && len1 && op_reg == `SFSC_OP_WR_ENABLE && !busy_reg;
   wire logic do_boost = frame_ok && len4 && op_reg == `SFSC_OP_BOOST;
   wire logic do_unboost = frame_ok && len1 && op_is_rls && !busy_reg;
   wire logic do_sus = frame_ok && len1 && op_reg == `SFSC_OP_SUSPEND && busy_reg && !any_sus;
   wire logic do_res = frame_ok && len1 && op_reg == `SFSC_OP_RESUME && any_sus && !busy_reg;
   wire logic sec_ok = latch_reg && !busy_reg && sel_ok && !locked;
   wire logic do_erase = frame_ok && len4 && op_reg == `SFSC_OP_SEC_ERASE && sec_ok
      && !any_sus;
   wire logic do_prog = frame_ok && byte_cnt_reg > `SFSC_LEN_ADDR && op_reg == `SFSC_OP_SEC_PROG
      && sec_ok && !sus_p_reg && buf_free;
   wire logic do_rsten = frame_ok && len1 && op_reg == `SFSC_OP_RST_EN;
   wire logic do_reset = frame_ok && len1 && op_reg == `SFSC_OP_RESET && rst_en_reg;
   wire logic erase_run = erase_act_reg && !sus_e_reg;
   wire logic prog_run = prog_act_reg && !sus_p_reg;
   wire logic erase_end = erase_run && erase_cnt_reg == 12'(ERASE_CYC - 1);
   wire logic prog_end = prog_run && prog_cnt_reg == 12'(PROG_CYC - 1);

   // serial shifter: in on rising, out on falling
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bit_cnt_reg <= 3'd0;
         byte_cnt_reg <= 3'd0;
         in_sh_reg <= 8'h00;
         op_reg <= 8'h00;
         addr_reg <= 24'h000000;
         rd_ptr_reg <= 10'h000;
         pg_ptr_reg <= 8'h00;
         uid_idx_reg <= 4'h0;
         out_sh_reg <= 8'h00;
         so_reg <= 1'b0;
         so_oe_n_reg <= 1'b1;
      end else if (cs_n) begin
         bit_cnt_reg <= 3'd0;
         byte_cnt_reg <= 3'd0;
         uid_idx_reg <= 4'h0;
         so_oe_n_reg <= 1'b1;
      end else begin
         if (rise_ev) begin
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            in_sh_reg <= byte_in;
         end
         if (byte_done) begin
            if (byte_cnt_reg != `SFSC_BYTE_SAT) begin
               byte_cnt_reg <= byte_cnt_reg + 3'd1;
            end
            if (byte_cnt_reg == 3'd0) begin
               op_reg <= byte_in;
            end
            if (!data_phase) begin
               addr_reg <= {addr_reg[15:0], byte_in};
            end
            if (byte_cnt_reg == `SFSC_ADDR_END) begin
               rd_ptr_reg <= {addr_reg[1:0], byte_in};
               pg_ptr_reg <= byte_in;
            end
         end
         if (buf_wr) begin
            pg_ptr_reg <= pg_ptr_reg + 8'd1;
         end
         if (out_load) begin
            out_sh_reg <= out_byte;
            so_oe_n_reg <= 1'b0;
            if (is_read) begin
               rd_ptr_reg <= rd_ptr_reg + 10'd1;
            end
            if (is_uid) begin
               uid_idx_reg <= uid_idx_reg + 4'd1;
            end
         end else if (fall_ev) begin
            so_reg <= out_sh_reg[7];
            out_sh_reg <= {out_sh_reg[6:0], 1'b0};
         end
      end
   end

   // page buffer; a running program owns it
   always_ff @(posedge clk) begin
      if (buf_wr) begin
         pbuf[pg_ptr_reg] <= byte_in;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pvalid_reg <= '0;
      end else if (buf_clr && buf_free) begin
         pvalid_reg <= '0;
      end else if (buf_wr) begin
         pvalid_reg[pg_ptr_reg] <= 1'b1;
      end
   end

   // status flags and self-timed jobs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_reg <= 1'b0;
         latch_reg <= 1'b0;
         sus_e_reg <= 1'b0;
         sus_p_reg <= 1'b0;
         boost_reg <= 1'b0;
         rst_en_reg <= 1'b0;
         erase_act_reg <= 1'b0;
         prog_act_reg <= 1'b0;
         erase_cnt_reg <= 12'd0;
         prog_cnt_reg <= 12'd0;
         erase_sel_reg <= 2'd0;
         prog_sel_reg <= 2'd0;
         prog_page_reg <= 2'd0;
         recov_cnt_reg <= 22'd0;
      end else if (do_reset) begin
         busy_reg <= 1'b0;
         latch_reg <= 1'b0;
         sus_e_reg <= 1'b0;
         sus_p_reg <= 1'b0;
         boost_reg <= 1'b0;
         rst_en_reg <= 1'b0;
         erase_act_reg <= 1'b0;
         prog_act_reg <= 1'b0;
         recov_cnt_reg <= erase_act_reg ? 22'(RST_E_CYC) : 22'(RST_CYC);
      end else begin
         if (recov) begin
            recov_cnt_reg <= recov_cnt_reg - 22'd1;
         end
         if (cs_rise) begin
            rst_en_reg <= do_rsten;
         end
         if (do_boost) begin
            boost_reg <= 1'b1;
         end else if (do_unboost) begin
            boost_reg <= 1'b0;
         end
         // latch drops as the cycle starts, well before it ends
         if (do_write_enable) begin
            latch_reg <= 1'b1;
         end else if (do_erase || do_prog) begin
            latch_reg <= 1'b0;
         end
         if (do_sus) begin
            sus_p_reg <= prog_run;
            sus_e_reg <= !prog_run;
         end else if (do_res) begin
            sus_p_reg <= 1'b0;
            sus_e_reg <= 1'b0;
         end
         if (do_erase || do_prog || do_res) begin
            busy_reg <= 1'b1;
         end else if (do_sus || erase_end || prog_end) begin
            busy_reg <= 1'b0;
         end
         if (do_erase) begin
            erase_act_reg <= 1'b1;
            erase_cnt_reg <= 12'd0;
            erase_sel_reg <= sel_idx;
         end else if (erase_end) begin
            erase_act_reg <= 1'b0;
         end else if (erase_run) begin
            erase_cnt_reg <= erase_cnt_reg + 12'd1;
         end
         if (do_prog) begin
            prog_act_reg <= 1'b1;
            prog_cnt_reg <= 12'd0;
            prog_sel_reg <= sel_idx;
            prog_page_reg <= addr_reg[`SFSC_A_PAGE];
         end else if (prog_end) begin
            prog_act_reg <= 1'b0;
         end else if (prog_run) begin
            prog_cnt_reg <= prog_cnt_reg + 12'd1;
         end
      end
   end

   // array walk: erase sets bytes, program only clears bits
   wire logic [11:0] erase_idx = {erase_sel_reg, erase_cnt_reg[9:0]};
   wire logic [11:0] prog_idx = {prog_sel_reg, prog_page_reg, prog_cnt_reg[7:0]};
   wire logic erase_wr = erase_run && erase_cnt_reg < `SFSC_SEC_BYTES && !do_reset;
   wire logic prog_wr = prog_run && prog_cnt_reg < `SFSC_PAGE_BYTES && !do_reset
      && pvalid_reg[prog_cnt_reg[7:0]];

   always_ff @(posedge clk) begin
      if (erase_wr) begin
         mem[erase_idx] <= `SFSC_ERASED;
      end else if (prog_wr) begin
         mem[prog_idx] <= mem[prog_idx] & pbuf[prog_cnt_reg[7:0]];
      end
   end

   assign link.so = so_reg;
   assign link.so_oe_n = so_oe_n_reg;
   assign op_in_progress_flag = busy_reg;
   assign write_latch = latch_reg;
   assign suspend_flags = {sus_p_reg, sus_e_reg};
   assign boost_flag = boost_reg;
endmodule
`default_nettype wire

/* logic/sfsc_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfsc_defs.svh"
module sfsc_host (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial link
   sfsc_if.host link
);
   import sfsc_pkg::*;

   sfsc_hstate_t state_reg;
   logic [31:0] tx0_reg, tx1_reg, prdata_reg;
   logic [3:0] ntx_reg, div_reg;
   logic [4:0] nrx_reg;
   logic [8:0] nbits_reg, bit_cnt_reg;
   logic [63:0] tx_sh_reg;
   logic [127:0] rx_sh_reg;
   logic [1:0] miso_sync_reg;
   logic cs_n_reg, sclk_reg, pready_reg, pslverr_reg;

   wire logic idle = state_reg == HS_IDLE;
   wire logic tick = !idle && div_reg == `SFSC_HALF_CYC - 4'd1;
   wire logic apb_setup = psel && !penable && !pready_reg;
   wire logic apb_wr = psel && penable && pready_reg && pwrite;
   wire logic wr_tx0 = apb_wr && paddr == `SFSC_REG_TX0;
   wire logic wr_tx1 = apb_wr && paddr == `SFSC_REG_TX1;
   wire logic wr_cmd = apb_wr && paddr == `SFSC_REG_CMD;
   // whole bytes only, so chip select always rises on a byte boundary
   wire logic [3:0] cmd_ntx = pwdata[`SFSC_CMD_NTX];
   wire logic [4:0] cmd_nrx = pwdata[`SFSC_CMD_NRX];
   wire logic start = wr_cmd && idle && cmd_ntx != 4'd0;
   wire logic last_bit = bit_cnt_reg == nbits_reg - 9'd1;
   wire logic [31:0] cmd_word = {19'd0, nrx_reg, 4'd0, ntx_reg};
   wire logic mapped = paddr[7:5] == 3'd0 && paddr[1:0] == 2'd0;
   wire logic [31:0] rd_word =
      (paddr == `SFSC_REG_TX0) ? tx0_reg :
      (paddr == `SFSC_REG_TX1) ? tx1_reg :
      (paddr == `SFSC_REG_CMD) ? cmd_word :
      (paddr == `SFSC_REG_STAT) ? {31'd0, !idle} :
      (paddr == `SFSC_REG_RX0) ? rx_sh_reg[127:96] :
      (paddr == `SFSC_REG_RX1) ? rx_sh_reg[95:64] :
      (paddr == `SFSC_REG_RX2) ? rx_sh_reg[63:32] :
      (paddr == `SFSC_REG_RX3) ? rx_sh_reg[31:0] : 32'h0000_0000;

   // one wait-free access phase per transfer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         tx0_reg <= 32'h0000_0000;
         tx1_reg <= 32'h0000_0000;
         ntx_reg <= 4'd0;
         nrx_reg <= 5'd0;
      end else begin
         pready_reg <= apb_setup;
         pslverr_reg <= apb_setup && !mapped;
         if (apb_setup) begin
            prdata_reg <= rd_word;
         end
         if (wr_tx0) begin
            tx0_reg <= pwdata;
         end
         if (wr_tx1) begin
            tx1_reg <= pwdata;
         end
         if (start) begin
            ntx_reg <= cmd_ntx;
            nrx_reg <= cmd_nrx;
         end
      end
   end

   // frame engine: mode 0, data changes while the clock is low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= HS_IDLE;
         div_reg <= 4'd0;
         cs_n_reg <= 1'b1;
         sclk_reg <= 1'b0;
         bit_cnt_reg <= 9'd0;
         nbits_reg <= 9'd0;
         tx_sh_reg <= 64'd0;
         rx_sh_reg <= 128'd0;
         miso_sync_reg <= 2'b11;
      end else begin
         miso_sync_reg <= {miso_sync_reg[0], link.so_line};
         div_reg <= (idle || tick) ? 4'd0 : div_reg + 4'd1;
         case (state_reg)
            HS_IDLE: begin
               if (start) begin
                  state_reg <= HS_LEAD;
                  cs_n_reg <= 1'b0;
                  bit_cnt_reg <= 9'd0;
                  nbits_reg <= {2'b00, cmd_ntx, 3'b000} + {1'b0, cmd_nrx, 3'b000};
                  tx_sh_reg <= {tx0_reg, tx1_reg};
               end
            end
            HS_LEAD: begin
               if (tick) begin
                  state_reg <= HS_XFER;
               end
            end
            HS_XFER: begin
               if (tick && !sclk_reg) begin
                  sclk_reg <= 1'b1;
                  rx_sh_reg <= {rx_sh_reg[126:0], miso_sync_reg[1]};
               end else if (tick) begin
                  sclk_reg <= 1'b0;
                  bit_cnt_reg <= bit_cnt_reg + 9'd1;
                  tx_sh_reg <= {tx_sh_reg[62:0], 1'b0};
                  if (last_bit) begin
                     state_reg <= HS_TRAIL;
                  end
               end
            end
            HS_TRAIL: begin
               if (tick) begin
                  state_reg <= HS_GAP;
                  cs_n_reg <= 1'b1;
               end
            end
            HS_GAP: begin
               if (tick) begin
                  state_reg <= HS_IDLE;
               end
            end
            default: begin
               state_reg <= HS_IDLE;
            end
         endcase
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign link.cs_n = cs_n_reg;
   assign link.sclk = sclk_reg;
   assign link.si = tx_sh_reg[63];
endmodule
`default_nettype wire

/* logic/sfsc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sfsc_if;
   logic cs_n;
   logic sclk;
   logic si;
   logic so;
   logic so_oe_n;
   wire logic so_line;
   // undriven output line floats high
   assign so_line = so_oe_n ? 1'b1 : so;
   modport dev (input cs_n, input sclk, input si, output so, output so_oe_n);
   modport host (output cs_n, output sclk, output si, input so_line);
endinterface
`default_nettype wire

/* logic/sfsc_pkg.sv */
`default_nettype none
package sfsc_pkg;
   typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_XFER, HS_TRAIL, HS_GAP} sfsc_hstate_t;
   typedef logic [1:0] sfsc_sel_t;
endpackage
`default_nettype wire

/* testbench/sfsc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sfsc_chk #(
   parameter int ERASE_CYC = 2048
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // link
   input wire logic cs_n,
   input wire logic so_oe_n,
   // device flags
   input wire logic op_in_progress_flag,
   input wire logic write_latch,
   input wire sfsc_pkg::sfsc_sel_t suspend_flags,
   input wire logic boost_flag
);
   import sfsc_pkg::*;
   logic [23:0] busy_run_reg;
   // suspend splits a job, so one unbroken busy stretch never exceeds an erase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) busy_run_reg <= 24'h0;
      else busy_run_reg <= op_in_progress_flag ? busy_run_reg + 24'h1 : 24'h0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_susp_when_busy: assert property ($rose(|suspend_flags) |-> $past(op_in_progress_flag))
      else $error("suspend taken while idle");
   a_susp_single: assert property (suspend_flags != 2'b11)
      else $error("both suspend flags set");
   a_susp_busy_drop: assert property ($rose(|suspend_flags) |=> !op_in_progress_flag)
      else $error("busy kept after suspend");
   a_resume_idle: assert property ($fell(|suspend_flags) |-> !$past(op_in_progress_flag))
      else $error("resume taken while busy");
   a_resume_busy: assert property ($fell(|suspend_flags) |=> op_in_progress_flag)
      else $error("busy not restored on resume");
   a_busy_after_cs: assert property ($rose(op_in_progress_flag) |-> cs_n)
      else $error("cycle started inside a frame");
   a_latch_cleared: assert property ($rose(op_in_progress_flag) && $past(suspend_flags, 2) == 2'b00
      |-> !write_latch)
      else $error("write latch kept at cycle start");
   a_busy_bounded: assert property (busy_run_reg <= ERASE_CYC + 1)
      else $error("busy too long");
   a_boost_frame: assert property ($rose(boost_flag) |-> cs_n)
      else $error("boost set inside a frame");
   a_boost_leave: assert property ($fell(boost_flag) |-> cs_n && !$past(op_in_progress_flag))
      else $error("boost left badly");
   a_oe_idle: assert property (cs_n [*8] |-> so_oe_n)
      else $error("output driven while deselected");
endmodule
`default_nettype wire

/* testbench/tb_serial_flash_secreg_suspend_cmds.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module tb_serial_flash_secreg_suspend_cmds;
   import sfsc_pkg::*;
   // arbitrary value
   localparam logic [127:0] UID = 128'h5a5a_0f0f_1234_8765_c3c3_abcd_0001_fffe;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pready, pslverr, se, op_in_progress_flag, write_latch, boost_flag;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, s = 32'h2c, d;
   logic [2:0] lock = 3'h0;
   logic [127:0] got;
   sfsc_sel_t suspend_flags;
   int mismatches = 0, total_checks = 0;
   sfsc_if link ();
   sfsc_dev #(.UNIQUE_ID(UID), .ERASE_CYC(1100), .PROG_CYC(300), .RST_CYC(400), .RST_E_CYC(800))
      i_sfsc_dev (.clk, .rst, .link(link.dev), .otp_lock_bits(lock), .op_in_progress_flag,
      .write_latch, .suspend_flags, .boost_flag);
   sfsc_host i_sfsc_host (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .link(link.host));
   sfsc_chk #(.ERASE_CYC(1100)) i_sfsc_chk (.clk, .rst, .cs_n(link.cs_n),
      .so_oe_n(link.so_oe_n), .op_in_progress_flag, .write_latch, .suspend_flags, .boost_flag);
   initial begin
      forever #2 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   // two programmed bytes at the top of a register, then the erased first byte
   function automatic logic [23:0] wrap_exp(input logic [15:0] v);
      return {v, 8'hff};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic frame(input logic [7:0] c, input logic [23:0] a, input logic [31:0] v,
      input logic [3:0] n, input logic [4:0] r);
      apb(1'b1, 8'h00, {c, a});
      apb(1'b1, 8'h04, v);
      apb(1'b1, 8'h08, {19'h0, r, 4'h0, n});
      do apb(1'b0, 8'h0c, 32'h0); while (rd[0] === 1'b1);
      // let the device's synchronisers and flag update settle
      repeat (8) @(posedge clk);
   endtask
   task automatic op(input logic [7:0] c);
      frame(c, 24'h0, 32'h0, 4'd1, 5'd0);
   endtask
   task automatic wait_idle();
      int i;
      for (i = 0; i < 3000 && op_in_progress_flag !== 1'b0; i++) @(posedge clk);
      // a job that never ends is a failure of its own
      if (i == 3000) begin
         mismatches++;
         report_and_stop();
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      apb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped", se, 1'b1)
      frame(8'ha3, 24'h0, 32'h0, 4'd3, 5'd0);
      `CHK("boost short", boost_flag, 1'b0)
      for (int i = 0; i < 2; i++) begin
         frame(8'ha3, 24'h0, 32'h0, 4'd4, 5'd0);
         `CHK("boost on", boost_flag, 1'b1)
         op(i ? 8'hb9 : 8'hab);
         `CHK("boost off", boost_flag, 1'b0)
      end
      op(8'hab);
      frame(8'h4b, 24'h0, 32'h0, 4'd5, 5'd16);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'(16 + 4 * i), 32'h0);
         got = {got[95:0], rd};
      end
      `CHK("unique id", got, UID)
      frame(8'h44, 24'h001000, 32'h0, 4'd4, 5'd0);
      `CHK("erase no latch", op_in_progress_flag, 1'b0)
      op(8'h06);
      `CHK("latch set", write_latch, 1'b1)
      frame(8'h44, 24'h004000, 32'h0, 4'd4, 5'd0);
      `CHK("erase bad select", op_in_progress_flag, 1'b0)
      frame(8'h44, 24'h001000, 32'h0, 4'd4, 5'd0);
      `CHK("erase busy", op_in_progress_flag, 1'b1)
      `CHK("latch cleared", write_latch, 1'b0)
      wait_idle();
      d = xs();
      op(8'h06);
      frame(8'h42, 24'h0013fe, {d[15:0], 16'h0}, 4'd6, 5'd0);
      wait_idle();
      frame(8'h48, 24'h0013fe, 32'h0, 4'd5, 5'd3);
      apb(1'b0, 8'h1c, 32'h0);
      `CHK("read wrap", rd[23:0], wrap_exp(d[15:0]))
      lock <= 3'b010;
      op(8'h06);
      frame(8'h42, 24'h002000, d, 4'd6, 5'd0);
      `CHK("locked program", op_in_progress_flag, 1'b0)
      frame(8'h44, 24'h002000, 32'h0, 4'd4, 5'd0);
      `CHK("locked erase", op_in_progress_flag, 1'b0)
      lock <= 3'b000;
      op(8'h06);
      frame(8'h44, 24'h003000, 32'h0, 4'd4, 5'd0);
      op(8'h75);
      `CHK("erase suspended", suspend_flags, 2'b01)
      `CHK("busy dropped", op_in_progress_flag, 1'b0)
      frame(8'h05, 24'h0, 32'h0, 4'd1, 5'd1);
      apb(1'b0, 8'h1c, 32'h0);
      `CHK("status byte", rd[7:0], 8'h04)
      op(8'h75);
      `CHK("second suspend", suspend_flags, 2'b01)
      op(8'h06);
      frame(8'h44, 24'h003000, 32'h0, 4'd4, 5'd0);
      `CHK("erase in suspend", op_in_progress_flag, 1'b0)
      frame(8'h42, 24'h001100, d, 4'd5, 5'd0);
      `CHK("program in suspend", op_in_progress_flag, 1'b1)
      op(8'h7a);
      `CHK("resume while busy", suspend_flags, 2'b01)
      wait_idle();
      op(8'h7a);
      `CHK("resumed", suspend_flags, 2'b00)
      `CHK("busy again", op_in_progress_flag, 1'b1)
      wait_idle();
      op(8'h06);
      frame(8'h42, 24'h001200, d, 4'd5, 5'd0);
      op(8'h75);
      `CHK("program suspended", suspend_flags, 2'b10)
      for (int i = 0; i < 2; i++) begin
         op(8'h06);
         frame(i ? 8'h42 : 8'h44, 24'h001300, d, i ? 4'd5 : 4'd4, 5'd0);
         `CHK("blocked in suspend", op_in_progress_flag, 1'b0)
      end
      op(8'h7a);
      wait_idle();
      op(8'h7a);
      op(8'h75);
      `CHK("idle suspend", suspend_flags, 2'b00)
      frame(8'ha3, 24'h0, 32'h0, 4'd4, 5'd0);
      frame(8'h05, 24'h0, 32'h0, 4'd1, 5'd1);
      apb(1'b0, 8'h1c, 32'h0);
      `CHK("status before reset", rd[7:0], 8'h12)
      op(8'h66);
      op(8'h06);
      op(8'h99);
      `CHK("reset needs enable", write_latch, 1'b1)
      op(8'h66);
      op(8'h99);
      `CHK("reset latch", write_latch, 1'b0)
      `CHK("reset boost", boost_flag, 1'b0)
      op(8'h06);
      `CHK("recovery refuse", write_latch, 1'b0)
      repeat (800) @(posedge clk);
      op(8'h06);
      `CHK("after recovery", write_latch, 1'b1)
      report_and_stop();
   end
endmodule
`default_nettype wire
